//--- hw/dmd_demand_core.sv
// Current scaling, power factor, line frequency and demand with min/max tracking
`timescale 1ns/1ps
// How it works
// - Clamp current readings to plus/minus 32767
// - Current equals reading times divisor over rated
// - Signed-amps option copies active power sign
// - Frequency reported in tenths of hertz
// - Frequency from highest-voltage channel, used everywhere
// - Negative active power gives negative power factor
// - Zero element power gives 1.0; inactive gives 0.0
// - Power factor stored in hundredths
// - Average factor is total watts over total VA
// - Window length 1 to 720 minutes, default 15
// - Demand averages signed power, may be negative
// - Rolling: 1-10 slices, full-window average per slice
// - Slice count zero or one means block demand
// - Demand reads zero until first full window
// - Rated amps, polarity, window or slice change zeroes demand and restarts window
// - Config restart leaves min and max alone
// - Keep lowest total demand, cleared by clear control
// - Keep highest total demand, cleared by clear control
// - Per-element demand, no min/max for them
// - Apparent demand uses total VA, same scheme
// - Integer demand divided by power multiplier
// - Channel inactive below 20% of higher reference
module dmd_demand_core #(
    parameter int SAMPLE_CYCLES = dmd_pkg::SAMPLE_CYCLES
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [15:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    input wire logic [2:0][31:0] ELEM_WATTS,
    input wire logic [2:0][31:0] ELEM_VA,
    input wire logic [2:0][23:0] ELEM_MILLIAMPS,
    input wire logic [2:0][15:0] ELEM_DECIVOLTS,
    input wire logic [2:0][15:0] ELEM_CENTIHZ,
    output logic [15:0] REG_RDATA,
    output logic REG_ACK,
    output logic DEMAND_VALID
);
    localparam int NCH = dmd_pkg::NCH;
    localparam int SW = dmd_pkg::SUM_W;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [2:0][15:0] rated_amps_r;
    logic [2:0] polarity_r;
    logic [15:0] power_mult_r, amp_divisor_r, signed_amps_r, nominal_r;
    logic [9:0] window_min_r;
    logic [3:0] slices_r;
    logic restart_r, clear_minmax_r;

    always_ff @(posedge CLK) begin
        restart_r <= 1'b0;
        clear_minmax_r <= 1'b0;
        if (SYS_RST) begin
            for (int i = 0; i < 3; i++) rated_amps_r[i] <= dmd_pkg::RST_RATED_AMPS;
            polarity_r <= 3'h0;
            power_mult_r <= dmd_pkg::RST_POWER_MULT;
            amp_divisor_r <= dmd_pkg::RST_AMP_DIVISOR;
            signed_amps_r <= dmd_pkg::RST_SIGNED_AMPS;
            nominal_r <= dmd_pkg::RST_NOMINAL_VOLTS;
            window_min_r <= dmd_pkg::RST_WINDOW_MIN;
            slices_r <= dmd_pkg::RST_WINDOW_SLICES;
            restart_r <= 1'b1;
        end else if (REG_WR) begin
            unique case (REG_ADDR)
                dmd_pkg::REG_RATED_AMPS0,
                dmd_pkg::REG_RATED_AMPS0 + 16'h0001,
                dmd_pkg::REG_RATED_AMPS0 + 16'h0002: begin
                    // Zero rated amps would divide by zero, so it is refused
                    if (REG_WDATA != 16'h0000) begin
                        rated_amps_r[REG_ADDR[1:0] - dmd_pkg::REG_RATED_AMPS0[1:0]] <= REG_WDATA;
                        restart_r <= 1'b1;
                    end
                end
                dmd_pkg::REG_POLARITY: begin
                    polarity_r <= REG_WDATA[2:0];
                    restart_r <= (REG_WDATA[2:0] != polarity_r);
                end
                dmd_pkg::REG_POWER_MULT: power_mult_r <= REG_WDATA;
                dmd_pkg::REG_AMP_DIVISOR: amp_divisor_r <= REG_WDATA;
                dmd_pkg::REG_SIGNED_AMPS: signed_amps_r <= REG_WDATA;
                dmd_pkg::REG_NOMINAL_VOLTS: nominal_r <= REG_WDATA;
                dmd_pkg::REG_WINDOW_MIN: begin
                    if (REG_WDATA >= 16'(dmd_pkg::MIN_MINUTES) &&
                        REG_WDATA <= 16'(dmd_pkg::MAX_MINUTES)) begin
                        window_min_r <= REG_WDATA[9:0];
                        restart_r <= (REG_WDATA[9:0] != window_min_r);
                    end
                end
                dmd_pkg::REG_WINDOW_SLICES: begin
                    if (REG_WDATA <= 16'(dmd_pkg::MAX_SLICES)) begin
                        slices_r <= REG_WDATA[3:0];
                        restart_r <= (REG_WDATA[3:0] != slices_r);
                    end
                end
                dmd_pkg::REG_WINDOW_CLEAR: begin
                    restart_r <= REG_WDATA[0];
                    clear_minmax_r <= REG_WDATA[1];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Element measurements
    // ------------------------------------------------------------
    logic [15:0] vmax, vref;
    logic [1:0] vsel;
    always_comb begin
        vmax = ELEM_DECIVOLTS[0];
        vsel = 2'd0;
        for (int i = 1; i < 3; i++) begin
            if (ELEM_DECIVOLTS[i] > vmax) begin
                vmax = ELEM_DECIVOLTS[i];
                vsel = 2'(i);
            end
        end
        vref = (nominal_r > vmax) ? nominal_r : vmax;
    end

    logic [2:0][15:0] amps_r, pf_r;
    logic signed [2:0][31:0] watts_act_r;
    logic [2:0][31:0] va_act_r;

    for (genvar g = 0; g < 3; g++) begin : g_elem
        logic signed [31:0] w;
        logic active;
        logic [39:0] amp_q;
        logic [15:0] amp_mag;
        logic signed [39:0] pf_q;
        assign w = polarity_r[g] ? -$signed(ELEM_WATTS[g]) : $signed(ELEM_WATTS[g]);
        assign active = (19'(ELEM_DECIVOLTS[g]) * 19'(dmd_pkg::INACTIVE_FRACTION_DEN))
            >= 19'(vref);
        assign amp_q = (40'(ELEM_MILLIAMPS[g]) * 40'(amp_divisor_r)) /
            (40'(rated_amps_r[g]) * 40'(dmd_pkg::MILLI_PER_AMP));
        assign amp_mag = (amp_q > 40'(dmd_pkg::READ_LIMIT)) ? dmd_pkg::READ_LIMIT
            : amp_q[15:0];
        assign pf_q = (ELEM_VA[g] == 32'h0) ? 40'sh0
            : (40'(w) * 40'sh64) / $signed({8'h00, ELEM_VA[g]});

        always_ff @(posedge CLK) begin
            if (SYS_RST) begin
                amps_r[g] <= 16'h0000;
                pf_r[g] <= 16'h0000;
                watts_act_r[g] <= 32'sh0;
                va_act_r[g] <= 32'h0;
            end else begin
                amps_r[g] <= (signed_amps_r == 16'h0001 && w < 0) ? -amp_mag : amp_mag;
                if (!active) begin
                    pf_r[g] <= 16'h0000;
                end else if (w == 0) begin
                    pf_r[g] <= dmd_pkg::PF_UNITY;
                end else if (pf_q > $signed(40'(dmd_pkg::PF_SCALE))) begin
                    pf_r[g] <= dmd_pkg::PF_SCALE;
                end else if (pf_q < -$signed(40'(dmd_pkg::PF_SCALE))) begin
                    pf_r[g] <= -dmd_pkg::PF_SCALE;
                end else begin
                    pf_r[g] <= pf_q[15:0];
                end
                watts_act_r[g] <= active ? w : 32'sh0;
                va_act_r[g] <= active ? ELEM_VA[g] : 32'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Totals, average power factor and frequency
    // ------------------------------------------------------------
    logic signed [33:0] tot_w;
    logic [33:0] tot_va;
    logic signed [41:0] avg_q;
    logic signed [33:0] tot_w_r;
    logic [33:0] tot_va_r;
    logic [15:0] avg_pf_r, freq_r;
    // Elements of a packed array read as unsigned, so each is sign-extended by hand
    assign tot_w = 34'($signed(watts_act_r[0])) + 34'($signed(watts_act_r[1]))
        + 34'($signed(watts_act_r[2]));
    assign tot_va = 34'(va_act_r[0]) + 34'(va_act_r[1]) + 34'(va_act_r[2]);
    assign avg_q = (tot_va == 34'h0) ? 42'sh0
        : (42'(tot_w) * 42'sh64) / $signed({8'h00, tot_va});

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tot_w_r <= 34'sh0;
            tot_va_r <= 34'h0;
            avg_pf_r <= 16'h0000;
            freq_r <= 16'h0000;
        end else begin
            tot_w_r <= tot_w;
            tot_va_r <= tot_va;
            avg_pf_r <= (tot_va == 34'h0) ? 16'h0000 : avg_q[15:0];
            freq_r <= ELEM_CENTIHZ[vsel] / dmd_pkg::FREQ_DIV;
        end
    end

    // ------------------------------------------------------------
    // Sample and slice timing
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_r;
    logic [15:0] sec_cnt_r;
    logic tick;
    logic [3:0] slices_eff;
    logic [15:0] slice_secs, win_secs;
    assign tick = (tick_cnt_r == 32'(SAMPLE_CYCLES - 1));
    assign slices_eff = (slices_r <= 4'h1) ? 4'h1 : slices_r;
    assign slice_secs = 16'((32'(window_min_r) * 32'(dmd_pkg::SECS_PER_MIN)) / 32'(slices_eff));
    assign win_secs = 16'(32'(slice_secs) * 32'(slices_eff));

    always_ff @(posedge CLK) begin
        if (SYS_RST || restart_r) begin
            tick_cnt_r <= 32'h0;
            sec_cnt_r <= 16'h0000;
        end else begin
            tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
            if (tick) begin
                sec_cnt_r <= (sec_cnt_r == slice_secs - 16'h0001) ? 16'h0000
                    : sec_cnt_r + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Demand engine
    // ------------------------------------------------------------
    dmd_mem_if mem_bus ();
    dmd_slot_mem u_mem (.CLK(CLK), .port(mem_bus.mem));

    dmd_pkg::dmd_state_t state_r;
    logic [3:0] ptr_r, filled_r;
    logic signed [NCH-1:0][SW-1:0] acc_r, pend_r, win_r;
    logic signed [NCH-1:0][15:0] dem_r;
    logic signed [NCH-1:0][SW-1:0] ch_in;
    logic slice_end;
    logic [31:0] dem_den;
    assign slice_end = tick && (sec_cnt_r == slice_secs - 16'h0001);
    assign dem_den = 32'(win_secs) * ((power_mult_r == 16'h0000) ? 32'h1
        : 32'(power_mult_r));
    assign ch_in[0] = SW'(tot_w_r);
    assign ch_in[4] = SW'(tot_va_r);
    assign mem_bus.addr = ptr_r;
    assign mem_bus.wr_en = (state_r == dmd_pkg::ST_MERGE);

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic signed [SW-1:0] old_sum, dem_q;
        if (c >= 1 && c <= 3) begin : g_el
            assign ch_in[c] = SW'($signed(watts_act_r[c-1]));
        end
        assign mem_bus.wdata[c*SW +: SW] = pend_r[c];
        assign old_sum = (filled_r == slices_eff) ? $signed(mem_bus.rdata[c*SW +: SW])
            : '0;
        assign dem_q = $signed(win_r[c]) / $signed({16'h0000, dem_den});

        always_ff @(posedge CLK) begin
            if (SYS_RST || restart_r) begin
                acc_r[c] <= '0;
                pend_r[c] <= '0;
                win_r[c] <= '0;
                dem_r[c] <= 16'sh0;
            end else begin
                if (tick && state_r == dmd_pkg::ST_IDLE && slice_end) begin
                    pend_r[c] <= acc_r[c] + ch_in[c];
                    acc_r[c] <= '0;
                end else if (tick) begin
                    acc_r[c] <= acc_r[c] + ch_in[c];
                end
                if (state_r == dmd_pkg::ST_MERGE) begin
                    win_r[c] <= win_r[c] + pend_r[c] - old_sum;
                end
                if (state_r == dmd_pkg::ST_SCALE && filled_r == slices_eff) begin
                    if (dem_q > $signed(SW'(dmd_pkg::READ_LIMIT))) begin
                        dem_r[c] <= dmd_pkg::READ_LIMIT;
                    end else if (dem_q < -$signed(SW'(dmd_pkg::READ_LIMIT))) begin
                        dem_r[c] <= -dmd_pkg::READ_LIMIT;
                    end else begin
                        dem_r[c] <= dem_q[15:0];
                    end
                end
            end
        end
    end

    // The slice timer never ends a slice within three cycles, so the
    // sequence below always returns to idle before the next boundary.
    always_ff @(posedge CLK) begin
        if (SYS_RST || restart_r) begin
            state_r <= dmd_pkg::ST_IDLE;
            ptr_r <= 4'h0;
            filled_r <= 4'h0;
            DEMAND_VALID <= 1'b0;
        end else begin
            unique case (state_r)
                dmd_pkg::ST_IDLE: if (tick && slice_end) state_r <= dmd_pkg::ST_FETCH;
                dmd_pkg::ST_FETCH: state_r <= dmd_pkg::ST_MERGE;
                dmd_pkg::ST_MERGE: begin
                    ptr_r <= (ptr_r == slices_eff - 4'h1) ? 4'h0 : ptr_r + 4'h1;
                    if (filled_r != slices_eff) filled_r <= filled_r + 4'h1;
                    state_r <= dmd_pkg::ST_SCALE;
                end
                dmd_pkg::ST_SCALE: begin
                    if (filled_r == slices_eff) DEMAND_VALID <= 1'b1;
                    state_r <= dmd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Lowest and highest total demand
    // ------------------------------------------------------------
    // Restarts do not touch these; only the clear control and every system
    // reset do, standing in for the retained copy.
    logic signed [15:0] dmin_r, dmax_r;
    logic seen_r, dem_upd_r;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            dem_upd_r <= 1'b0;
        end else begin
            dem_upd_r <= (state_r == dmd_pkg::ST_SCALE) && (filled_r == slices_eff) && !restart_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST || clear_minmax_r) begin
            seen_r <= 1'b0;
            dmin_r <= 16'sh0;
            dmax_r <= 16'sh0;
        end else if (dem_upd_r) begin
            seen_r <= 1'b1;
            if (!seen_r || $signed(dem_r[0]) < dmin_r) dmin_r <= dem_r[0];
            if (!seen_r || $signed(dem_r[0]) > dmax_r) dmax_r <= dem_r[0];
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    logic [15:0] rd_mux;
    always_comb begin
        unique case (REG_ADDR)
            dmd_pkg::REG_ELEM_AMPS0: rd_mux = amps_r[0];
            dmd_pkg::REG_ELEM_AMPS0 + 16'h0001: rd_mux = amps_r[1];
            dmd_pkg::REG_ELEM_AMPS0 + 16'h0002: rd_mux = amps_r[2];
            dmd_pkg::REG_TOTAL_DEMAND: rd_mux = dem_r[0];
            dmd_pkg::REG_DEMAND_MIN: rd_mux = dmin_r;
            dmd_pkg::REG_DEMAND_MAX: rd_mux = dmax_r;
            dmd_pkg::REG_APP_DEMAND: rd_mux = dem_r[4];
            dmd_pkg::REG_ELEM_DEMAND0: rd_mux = dem_r[1];
            dmd_pkg::REG_ELEM_DEMAND0 + 16'h0001: rd_mux = dem_r[2];
            dmd_pkg::REG_ELEM_DEMAND0 + 16'h0002: rd_mux = dem_r[3];
            dmd_pkg::REG_ELEM_PF0: rd_mux = pf_r[0];
            dmd_pkg::REG_ELEM_PF0 + 16'h0001: rd_mux = pf_r[1];
            dmd_pkg::REG_ELEM_PF0 + 16'h0002: rd_mux = pf_r[2];
            dmd_pkg::REG_TOTAL_PF: rd_mux = avg_pf_r;
            dmd_pkg::REG_LINE_FREQ: rd_mux = freq_r;
            dmd_pkg::REG_RATED_AMPS0: rd_mux = rated_amps_r[0];
            dmd_pkg::REG_RATED_AMPS0 + 16'h0001: rd_mux = rated_amps_r[1];
            dmd_pkg::REG_RATED_AMPS0 + 16'h0002: rd_mux = rated_amps_r[2];
            dmd_pkg::REG_POLARITY: rd_mux = {13'h0000, polarity_r};
            dmd_pkg::REG_POWER_MULT: rd_mux = power_mult_r;
            dmd_pkg::REG_AMP_DIVISOR: rd_mux = amp_divisor_r;
            dmd_pkg::REG_SIGNED_AMPS: rd_mux = signed_amps_r;
            dmd_pkg::REG_WINDOW_MIN: rd_mux = {6'h00, window_min_r};
            dmd_pkg::REG_WINDOW_SLICES: rd_mux = {12'h000, slices_r};
            dmd_pkg::REG_NOMINAL_VOLTS: rd_mux = nominal_r;
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 16'h0000;
            REG_ACK <= 1'b0;
        end else begin
            REG_RDATA <= REG_RD ? rd_mux : 16'h0000;
            REG_ACK <= REG_RD || REG_WR;
        end
    end
endmodule : dmd_demand_core

//--- hw/dmd_mem_if.sv
// Port bundle between the demand core and its slot memory
`timescale 1ns/1ps
interface dmd_mem_if;
    logic [3:0] addr;
    logic wr_en;
    logic [dmd_pkg::SLOT_W-1:0] wdata;
    logic [dmd_pkg::SLOT_W-1:0] rdata;
    modport core (output addr, output wr_en, output wdata, input rdata);
    modport mem (input addr, input wr_en, input wdata, output rdata);
endinterface : dmd_mem_if

//--- hw/dmd_pkg.sv
// Shared constants, register map and types of the demand and derived-metrics block
package dmd_pkg;
    // --------------------------------------------------------------
    // Clock and timing
    // --------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int SAMPLE_PERIOD_S = 1;
    localparam int SAMPLE_CYCLES = CLK_HZ * SAMPLE_PERIOD_S;
    localparam int SECS_PER_MIN = 60;

    // --------------------------------------------------------------
    // Structure
    // --------------------------------------------------------------
    localparam int NEL = 3;
    localparam int NCH = 5;
    localparam int SLOTS = 10;
    localparam int SUM_W = 48;
    localparam int SLOT_W = NCH * SUM_W;
    localparam logic [3:0] MAX_SLICES = 4'ha;
    localparam logic [9:0] MIN_MINUTES = 10'h001;
    localparam logic [9:0] MAX_MINUTES = 10'h2d0;

    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [15:0] REG_ELEM_AMPS0 = 16'h0547;
    localparam logic [15:0] REG_TOTAL_DEMAND = 16'h054a;
    localparam logic [15:0] REG_DEMAND_MIN = 16'h054b;
    localparam logic [15:0] REG_DEMAND_MAX = 16'h054c;
    localparam logic [15:0] REG_APP_DEMAND = 16'h054d;
    localparam logic [15:0] REG_ELEM_DEMAND0 = 16'h054e;
    localparam logic [15:0] REG_ELEM_PF0 = 16'h0551;
    localparam logic [15:0] REG_TOTAL_PF = 16'h0554;
    localparam logic [15:0] REG_LINE_FREQ = 16'h0555;
    localparam logic [15:0] REG_RATED_AMPS0 = 16'h0644;
    localparam logic [15:0] REG_POLARITY = 16'h0647;
    localparam logic [15:0] REG_POWER_MULT = 16'h0649;
    localparam logic [15:0] REG_AMP_DIVISOR = 16'h0656;
    localparam logic [15:0] REG_SIGNED_AMPS = 16'h0695;
    localparam logic [15:0] REG_WINDOW_MIN = 16'h06a0;
    localparam logic [15:0] REG_WINDOW_SLICES = 16'h06a1;
    localparam logic [15:0] REG_WINDOW_CLEAR = 16'h06a2;
    localparam logic [15:0] REG_NOMINAL_VOLTS = 16'h06a3;

    // --------------------------------------------------------------
    // Reset values and fixed figures
    // --------------------------------------------------------------
    localparam logic [15:0] RST_AMP_DIVISOR = 16'h4e20;
    localparam logic [15:0] RST_RATED_AMPS = 16'h0064;
    localparam logic [15:0] RST_POWER_MULT = 16'h0000;
    localparam logic [15:0] RST_SIGNED_AMPS = 16'h0000;
    localparam logic [9:0] RST_WINDOW_MIN = 10'h00f;
    localparam logic [3:0] RST_WINDOW_SLICES = 4'h1;
    localparam logic [15:0] RST_NOMINAL_VOLTS = 16'h04b0;
    localparam logic [15:0] READ_LIMIT = 16'h7fff;
    localparam logic [15:0] PF_UNITY = 16'h0064;
    localparam logic [15:0] PF_SCALE = 16'h0064;
    localparam logic [15:0] FREQ_DIV = 16'h000a;
    localparam logic [15:0] MILLI_PER_AMP = 16'h03e8;
    localparam logic [2:0] INACTIVE_FRACTION_DEN = 3'h5;

    typedef enum {ST_IDLE, ST_FETCH, ST_MERGE, ST_SCALE} dmd_state_t;
endpackage : dmd_pkg

//--- hw/dmd_slot_mem.sv
// Circular store of per-slice power sums, registered read
`timescale 1ns/1ps
module dmd_slot_mem (
    input wire logic CLK,
    dmd_mem_if.mem port
);
    logic [dmd_pkg::SLOT_W-1:0] mem_q [dmd_pkg::SLOTS];

    always_ff @(posedge CLK) begin
        if (port.wr_en) begin
            mem_q[port.addr] <= port.wdata;
        end
        port.rdata <= mem_q[port.addr];
    end
endmodule : dmd_slot_mem

//--- verif/dmd_core_sva.sv
// Port assertions of the demand core
`timescale 1ns/1ps
module dmd_core_sva #(
    parameter int SAMPLE_CYCLES = 4
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [15:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_ACK,
    input wire logic DEMAND_VALID
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    sequence s_rd(a);
        REG_RD && REG_ADDR == a;
    endsequence
    a_ack_follows: assert property ((REG_RD || REG_WR) |=> REG_ACK) else $error("ack missing");
    a_ack_cause: assert property (REG_ACK |-> $past(REG_RD || REG_WR)) else $error("stray ack");
    a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 16'h0000) else $error("data not idle");
    a_amps_clamp: assert property (s_rd(16'h0547) |=> REG_RDATA != 16'h8000)
        else $error("current beyond limit");
    a_pf_range: assert property (s_rd(16'h0551) |=>
        $signed(REG_RDATA) <= 16'sd100 && $signed(REG_RDATA) >= -16'sd100) else $error("pf range");
    a_demand_zero: assert property ((s_rd(16'h054a) ##0 !DEMAND_VALID ##1 !DEMAND_VALID)
        |-> REG_RDATA == 16'h0000) else $error("demand before full window");
    a_restart_clears: assert property (REG_WR && REG_ADDR == 16'h06a2 && REG_WDATA[0]
        |-> ##2 !DEMAND_VALID) else $error("restart kept demand");
    a_valid_fall: assert property ($fell(DEMAND_VALID) |-> $past(REG_WR) || $past(REG_WR, 2))
        else $error("demand dropped without write");
endmodule : dmd_core_sva

//--- verif/dmd_demand_core_tb.sv
// Self-checking bench of the demand core
`timescale 1ns/1ps
module dmd_demand_core_tb;
    logic clk, sys_rst, reg_wr, reg_rd, reg_ack, demand_valid;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0][31:0] watts, va;
    logic [2:0][23:0] ma;
    logic [2:0][15:0] dv, hz;
    int err_total, n_checks;
    dmd_demand_core #(.SAMPLE_CYCLES(4)) i_dut (.CLK(clk), .SYS_RST(sys_rst),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
        .ELEM_WATTS(watts), .ELEM_VA(va), .ELEM_MILLIAMPS(ma), .ELEM_DECIVOLTS(dv),
        .ELEM_CENTIHZ(hz), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack), .DEMAND_VALID(demand_valid));
    dmd_host_model i_host (.clk(clk), .ack(reg_ack), .rdata(reg_rdata), .addr(reg_addr),
        .wr(reg_wr), .rd(reg_rd), .wdata(reg_wdata));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] s, e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [15:0] a, d, e);
        logic [15:0] q;
        logic ok;
        i_host.xfer(w, a, d, q, ok);
        if (ok !== 1'b1) begin
            err_total++;
            end_sim();
        end
        if (!w) begin
            chk(q, e);
        end
    endtask : bus
    // Inputs settle for four cycles since totals lag the inputs by two
    task automatic st;
        repeat (4) @(negedge clk);
    endtask : st
    task automatic wv;
        for (int n = 0; n < 800 && demand_valid !== 1'b1; n++) begin
            @(negedge clk);
        end
        if (demand_valid !== 1'b1) begin
            err_total++;
            end_sim();
        end
    endtask : wv
    task automatic t_amps;
        bus(0, 16'h0656, 0, 16'h4e20);
        bus(0, 16'h0547, 0, 16'd1000);
        ma[0] = 24'd200000;
        st();
        bus(0, 16'h0547, 0, 16'h7fff);
        {ma[0], watts[0]} = {24'd5000, -32'sd600};
        bus(0, 16'h0695, 0, 16'h0000);
        bus(1, 16'h0695, 16'h0001, 0);
        st();
        bus(0, 16'h0547, 0, 16'hfc18);
        $display("t_amps done");
    endtask : t_amps
    task automatic t_pf;
        {watts, dv[2], hz[2]} = {32'd450, 32'd850, -32'sd850, 16'd2400, 16'd5000};
        st();
        bus(0, 16'h0551, 0, 16'hffab);
        bus(0, 16'h0552, 0, 16'h0055);
        bus(0, 16'h0555, 0, 16'h01f4);
        watts[1] = 32'h0;
        st();
        bus(0, 16'h0552, 0, 16'h0064);
        {watts[1], dv[1]} = {32'd850, 16'd100};
        st();
        bus(0, 16'h0552, 0, 16'h0000);
        bus(0, 16'h0554, 0, 16'hffec);
        $display("t_pf done");
    endtask : t_pf
    task automatic t_demand;
        {dv, watts} = {{3{16'd1200}}, 64'h0, -32'sd600};
        bus(1, 16'h0649, 16'h000a, 0);
        bus(1, 16'h06a0, 16'h02d1, 0);
        bus(0, 16'h06a0, 0, 16'h000f);
        bus(1, 16'h06a1, 16'h0000, 0);
        bus(1, 16'h06a0, 16'h0001, 0);
        bus(0, 16'h054a, 0, 16'h0000);
        wv();
        bus(0, 16'h054a, 0, 16'hffc4);
        bus(0, 16'h054e, 0, 16'hffc4);
        bus(0, 16'h054d, 0, 16'h012c);
        $display("t_demand done");
    endtask : t_demand
    task automatic t_restart;
        bus(1, 16'h0644, 16'd200, 0);
        bus(0, 16'h054a, 0, 16'h0000);
        chk({15'h0000, demand_valid}, 16'h0000);
        bus(0, 16'h054c, 0, 16'hffc4);
        watts[0] = 32'd1200;
        st();
        bus(1, 16'h06a2, 16'h0001, 0);
        wv();
        bus(0, 16'h054a, 0, 16'h0078);
        bus(0, 16'h054b, 0, 16'hffc4);
        bus(0, 16'h054c, 0, 16'h0078);
        bus(1, 16'h06a2, 16'h0003, 0);
        bus(0, 16'h054b, 0, 16'h0000);
        bus(0, 16'h054c, 0, 16'h0000);
        $display("t_restart done");
    endtask : t_restart
    // Power drops as the window first fills; the rolling window shows half of it a slice later, all of it two slices later
    task automatic t_roll;
        bus(1, 16'h0649, 16'h0064, 0);
        bus(1, 16'h06a1, 16'h000b, 0);
        bus(0, 16'h06a1, 0, 16'h0000);
        bus(1, 16'h06a1, 16'h0002, 0);
        wv();
        watts[0] = 32'd600;
        bus(0, 16'h054a, 0, 16'h000c);
        repeat (160) @(negedge clk);
        bus(0, 16'h054a, 0, 16'h0009);
        repeat (120) @(negedge clk);
        bus(0, 16'h054a, 0, 16'h0006);
        $display("t_roll done");
    endtask : t_roll
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {err_total, n_checks, sys_rst} = {32'd0, 32'd0, 1'b1};
        {watts, va, ma} = {{3{32'd850}}, {3{32'd1000}}, {3{24'd5000}}};
        {dv, hz} = {{3{16'd1200}}, {3{16'd6000}}};
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        t_amps();
        t_pf();
        t_demand();
        t_restart();
        t_roll();
        end_sim();
    end
endmodule : dmd_demand_core_tb
bind dmd_demand_core dmd_core_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_sva (.CLK(CLK),
    .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .DEMAND_VALID(DEMAND_VALID));

//--- verif/dmd_host_model.sv
// Register host model polling the demand core
`timescale 1ns/1ps
module dmd_host_model (
    input wire logic clk,
    input wire logic ack,
    input wire logic [15:0] rdata,
    output logic [15:0] addr,
    output logic wr,
    output logic rd,
    output logic [15:0] wdata
);
    initial {addr, wr, rd, wdata} = '0;
    // One-cycle strobe; address held one cycle past the ack sample, then shown inverted as released
    task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] q,
        output logic ok);
        @(negedge clk);
        {addr, wdata, wr, rd} = {a, d, w, !w};
        @(negedge clk);
        {wr, rd} = 2'b00;
        ok = ack;
        q = rdata;
        @(negedge clk);
        {addr, wdata} = {~a, ~d};
    endtask : xfer
endmodule : dmd_host_model
